// >>> core/smpc_pkg.sv
// Package for the sleep mode power controller: modes, constants, carriers
package smpc_pkg;

   typedef enum logic [2:0] {
      SMPC_MODE_IDLE    = 3'h0,
      SMPC_MODE_QUIET   = 3'h1,
      SMPC_MODE_PDOWN   = 3'h2,
      SMPC_MODE_PSAVE   = 3'h3,
      SMPC_MODE_RES4    = 3'h4,
      SMPC_MODE_RES5    = 3'h5,
      SMPC_MODE_STANDBY = 3'h6,
      SMPC_MODE_EXTSTBY = 3'h7
   } smpc_mode_e;

   typedef enum logic [1:0] {
      SMPC_ST_RUN   = 2'h0,
      SMPC_ST_SLEEP = 2'h1,
      SMPC_ST_START = 2'h2,
      SMPC_ST_HALT  = 2'h3
   } smpc_state_e;

   // Clock domain enables, one bit per domain
   typedef struct packed {
      logic cpu;
      logic flash;
      logic io;
      logic adc;
      logic tmr2_sync;
      logic tmr2_async;
      logic main_osc;
   } smpc_clk_s;

   // Wake sources seen while sleeping
   typedef struct packed {
      logic ext_low;
      logic ext_high;
      logic pin_change;
      logic addr_match;
      logic twi_irq;
      logic wdt_irq;
      logic adc_done;
      logic store_ready;
      logic tmr2_irq;
      logic periph_irq;
   } smpc_wake_s;

   localparam int  SMPC_CLK_MHZ        = 250;
   localparam int  SMPC_HALT_CYCLES    = 4;
   localparam int  SMPC_STANDBY_CYCLES = 6;
   localparam int  SMPC_BOD_WAKE_US    = 60;
   localparam int  SMPC_BOD_WAKE_CYC   = SMPC_BOD_WAKE_US * SMPC_CLK_MHZ;
   localparam int  SMPC_UNLOCK_CYCLES  = 4;
   localparam int  SMPC_BROWNOUT_SLEEP_OFF_DELAY     = 3;
   localparam int  SMPC_BROWNOUT_SLEEP_OFF_HOLD      = 3;
   localparam int  SMPC_CNT_W          = 16;
   localparam int  SMPC_PRR_W          = 8;
   localparam logic [SMPC_PRR_W-1:0] SMPC_PRR_RESET = 8'h00;
   localparam int  SMPC_BROWNOUT_SLEEP_OFF_BIT       = 6;
   localparam logic SMPC_BROWNOUT_SLEEP_OFF_RESET    = 1'b0;

endpackage

// >>> core/smpc_brownout_sleep_off_seq.sv
// Timed unlock sequence for the brown-out sleep-off control bit
`timescale 1ns/10ps
`default_nettype none
module smpc_brownout_sleep_off_seq (
   // Clock and reset
   input  wire logic ref_clk_in,
   input  wire logic reset_in,
   // Control register write
   input  wire logic ctrl_wr_in,
   input  wire logic sleep_off_in,
   input  wire logic unlock_in,
   // Status
   output logic      unlock_open_out,
   output logic      sleep_off_active_out
);
   logic [2:0] win_r;
   logic [2:0] dly_r;
   logic [2:0] hold_r;
   logic       open_w;
   logic       arm_w;

   assign open_w  = (win_r != 3'h0);
   assign arm_w   = ctrl_wr_in && sleep_off_in && !unlock_in && open_w;

   // Unlock window opens on a write with both bits one
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         win_r  <= 3'h0;
         dly_r  <= 3'h0;
         hold_r <= 3'h0;
      end else begin
         if (ctrl_wr_in && sleep_off_in && unlock_in) begin
            win_r <= 3'(smpc_pkg::SMPC_UNLOCK_CYCLES);
         end else if (arm_w) begin
            win_r <= 3'h0;
         end else if (open_w) begin
            win_r <= win_r - 3'h1;
         end
         if (arm_w) begin
            dly_r <= 3'(smpc_pkg::SMPC_BROWNOUT_SLEEP_OFF_DELAY);
         end else if (dly_r != 3'h0) begin
            dly_r <= dly_r - 3'h1;
         end
         if (dly_r == 3'h1) begin
            hold_r <= 3'(smpc_pkg::SMPC_BROWNOUT_SLEEP_OFF_HOLD);
         end else if (hold_r != 3'h0) begin
            hold_r <= hold_r - 3'h1;
         end
      end
   end

   assign unlock_open_out      = open_w;
   assign sleep_off_active_out = (hold_r != 3'h0);

   property p_brownout_sleep_off_active_after_arm;
      @(posedge ref_clk_in) disable iff (reset_in)
      arm_w |-> !sleep_off_active_out ##4 sleep_off_active_out[*3] ##1 !sleep_off_active_out;
   endproperty
   a_brownout_sleep_off_active_after_arm: assert property (p_brownout_sleep_off_active_after_arm) else $error("sleep-off timing wrong");

   property p_brownout_sleep_off_needs_window;
      @(posedge ref_clk_in) disable iff (reset_in)
      $rose(sleep_off_active_out) |-> $past(arm_w, 4);
   endproperty
   a_brownout_sleep_off_needs_window: assert property (p_brownout_sleep_off_needs_window) else $error("sleep-off set without unlock");

endmodule
`default_nettype wire

// >>> core/smpc_top.sv
// Sleep mode power controller: mode decode, clock gating, wake sequencing
`timescale 1ns/10ps
`default_nettype none
module smpc_top #(
   parameter int PRR_W        = smpc_pkg::SMPC_PRR_W,
   parameter int BOD_WAKE_CYC = smpc_pkg::SMPC_BOD_WAKE_CYC,
   parameter int CNT_W        = smpc_pkg::SMPC_CNT_W
) (
   // Clock and reset
   input  wire logic                 ref_clk_in,
   input  wire logic                 reset_in,
   // Sleep control from core
   input  wire logic                 sleep_arm_bit_in,
   input  wire logic [2:0]           sleep_mode_select_in,
   input  wire logic                 sleep_instr_in,
   input  wire logic                 ext_crystal_in,
   input  wire logic [CNT_W-1:0]     startup_cycles_in,
   // Brown-out sleep-off control write
   input  wire logic                 mcu_ctrl_wr_in,
   input  wire logic                 brownout_sleep_off_in,
   input  wire logic                 brownout_sleep_off_unlock_in,
   // Peripheral clock gating
   input  wire logic [PRR_W-1:0]     peripheral_clock_gate_in,
   // Wake sources
   input  wire smpc_pkg::smpc_wake_s wake_in,
   input  wire logic                 any_reset_in,
   input  wire logic                 global_irq_en_in,
   input  wire logic                 tmr2_enabled_in,
   input  wire logic                 tmr2_async_in,
   input  wire logic                 adc_enabled_in,
   // Clock domain enables and status
   output var smpc_pkg::smpc_clk_s   clk_en_out,
   output logic [PRR_W-1:0]          periph_clk_en_out,
   output logic [PRR_W-1:0]          periph_access_ok_out,
   output logic                      core_halt_out,
   output logic                      resume_irq_out,
   output logic                      reset_vector_out,
   output logic                      adc_start_out,
   output logic                      brownout_detector_en_out,
   output logic                      brownout_sleep_off_out,
   output logic                      sleeping_out,
   output logic [2:0]                active_mode_out
);
   smpc_pkg::smpc_state_e state_r;
   smpc_pkg::smpc_state_e state_nxt;
   smpc_pkg::smpc_mode_e  mode_r;
   logic [CNT_W-1:0]      cnt_r;
   logic [CNT_W-1:0]      cnt_nxt;
   logic                  bod_off_r;
   logic                  sleep_off_active_w;
   logic                  enter_w;
   logic                  valid_mode_w;
   logic                  wake_w;
   logic                  standby_w;
   logic                  tmr2_wake_w;
   logic                  deep_w;
   logic                  osc_keep_w;
   logic [CNT_W-1:0]      start_len_w;
   smpc_pkg::smpc_clk_s   clk_nxt;
   smpc_pkg::smpc_clk_s   clk_r;
   logic                  adc_start_r;
   logic                  reset_vec_r;
   logic                  resume_r;

   // Mode is legal: reserved codes never sleep; standby codes need a crystal
   function automatic logic mode_ok(input logic [2:0] m, input logic xtal);
      mode_ok = (m <= 3'h3) || (m >= 3'h6 && xtal);
   endfunction

   assign valid_mode_w = mode_ok(sleep_mode_select_in, ext_crystal_in);
   assign enter_w      = (state_r == smpc_pkg::SMPC_ST_RUN) && sleep_arm_bit_in
                         && sleep_instr_in && valid_mode_w;
   assign standby_w    = (mode_r == smpc_pkg::SMPC_MODE_STANDBY) || (mode_r == smpc_pkg::SMPC_MODE_EXTSTBY);
   assign deep_w       = (mode_r >= smpc_pkg::SMPC_MODE_PDOWN);
   assign osc_keep_w   = standby_w;
   assign tmr2_wake_w  = tmr2_enabled_in && global_irq_en_in && wake_in.tmr2_irq;

   // Wake source filter per mode
   always_comb begin
      case (mode_r)
         smpc_pkg::SMPC_MODE_IDLE:
            wake_w = |wake_in;
         smpc_pkg::SMPC_MODE_QUIET:
            wake_w = wake_in.adc_done || wake_in.wdt_irq || wake_in.twi_irq || wake_in.tmr2_irq
                     || wake_in.store_ready || wake_in.ext_high || wake_in.ext_low
                     || wake_in.pin_change;
         smpc_pkg::SMPC_MODE_PDOWN, smpc_pkg::SMPC_MODE_STANDBY:
            wake_w = wake_in.addr_match || wake_in.ext_low || wake_in.pin_change
                     || wake_in.wdt_irq;
         smpc_pkg::SMPC_MODE_PSAVE, smpc_pkg::SMPC_MODE_EXTSTBY:
            wake_w = wake_in.addr_match || wake_in.ext_low || wake_in.pin_change
                     || wake_in.wdt_irq || tmr2_wake_w;
         default:
            wake_w = 1'b0;
      endcase
   end

   // Restart length: standby six cycles, deep modes fuse start-up, long if detector was off
   assign start_len_w = bod_off_r ? CNT_W'(BOD_WAKE_CYC) :
                        standby_w ? CNT_W'(smpc_pkg::SMPC_STANDBY_CYCLES) :
                        deep_w    ? startup_cycles_in :
                        CNT_W'(1);

   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      case (state_r)
         smpc_pkg::SMPC_ST_RUN: begin
            if (enter_w) begin
               state_nxt = smpc_pkg::SMPC_ST_SLEEP;
            end
         end
         smpc_pkg::SMPC_ST_SLEEP: begin
            if (wake_w) begin
               state_nxt = smpc_pkg::SMPC_ST_START;
               cnt_nxt   = start_len_w;
            end
         end
         smpc_pkg::SMPC_ST_START: begin
            if (cnt_r <= CNT_W'(1)) begin
               state_nxt = smpc_pkg::SMPC_ST_HALT;
               cnt_nxt   = CNT_W'(smpc_pkg::SMPC_HALT_CYCLES);
            end else begin
               cnt_nxt = cnt_r - CNT_W'(1);
            end
         end
         smpc_pkg::SMPC_ST_HALT: begin
            if (cnt_r <= CNT_W'(1)) begin
               state_nxt = smpc_pkg::SMPC_ST_RUN;
            end else begin
               cnt_nxt = cnt_r - CNT_W'(1);
            end
         end
         default: begin
            state_nxt = smpc_pkg::SMPC_ST_RUN;
         end
      endcase
      // Reset wins over any wake path and restarts at the vector
      if (any_reset_in && state_r != smpc_pkg::SMPC_ST_RUN) begin
         state_nxt = smpc_pkg::SMPC_ST_RUN;
         cnt_nxt   = '0;
      end
   end

   // Clock domain plan per state and mode
   always_comb begin
      clk_nxt = '1;
      if (state_r == smpc_pkg::SMPC_ST_SLEEP) begin
         clk_nxt.cpu   = 1'b0;
         clk_nxt.flash = 1'b0;
         case (mode_r)
            smpc_pkg::SMPC_MODE_IDLE: begin
            end
            smpc_pkg::SMPC_MODE_QUIET: begin
               clk_nxt.io = 1'b0;
            end
            smpc_pkg::SMPC_MODE_PDOWN, smpc_pkg::SMPC_MODE_STANDBY: begin
               clk_nxt.io         = 1'b0;
               clk_nxt.adc        = 1'b0;
               clk_nxt.tmr2_sync  = 1'b0;
               clk_nxt.tmr2_async = 1'b0;
               clk_nxt.main_osc   = osc_keep_w;
            end
            smpc_pkg::SMPC_MODE_PSAVE, smpc_pkg::SMPC_MODE_EXTSTBY: begin
               clk_nxt.io         = 1'b0;
               clk_nxt.adc        = 1'b0;
               clk_nxt.tmr2_sync  = tmr2_enabled_in && !tmr2_async_in;
               clk_nxt.tmr2_async = tmr2_enabled_in && tmr2_async_in;
               clk_nxt.main_osc   = osc_keep_w || clk_nxt.tmr2_sync;
            end
            default: begin
            end
         endcase
      end else if (state_r != smpc_pkg::SMPC_ST_RUN) begin
         // Clocks restart, core stays halted
         clk_nxt.cpu = 1'b0;
      end
   end

   // Only clocks are stopped; storage is never reset or written on wake
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         state_r     <= smpc_pkg::SMPC_ST_RUN;
         mode_r      <= smpc_pkg::SMPC_MODE_IDLE;
         cnt_r       <= '0;
         bod_off_r   <= 1'b0;
         clk_r       <= '1;
         adc_start_r <= 1'b0;
         reset_vec_r <= 1'b0;
         resume_r    <= 1'b0;
      end else begin
         state_r     <= state_nxt;
         cnt_r       <= cnt_nxt;
         clk_r       <= clk_nxt;
         if (enter_w) begin
            mode_r <= smpc_pkg::smpc_mode_e'(sleep_mode_select_in);
         end
         // Detector off only in deep modes entered while the sleep-off bit is live
         if (enter_w) begin
            bod_off_r <= sleep_off_active_w && (sleep_mode_select_in >= 3'h2);
         end else if (state_r == smpc_pkg::SMPC_ST_HALT || state_nxt == smpc_pkg::SMPC_ST_RUN) begin
            bod_off_r <= bod_off_r && state_r == smpc_pkg::SMPC_ST_SLEEP && state_nxt != smpc_pkg::SMPC_ST_RUN;
         end
         adc_start_r <= enter_w && adc_enabled_in
                        && (sleep_mode_select_in <= 3'h1);
         reset_vec_r <= any_reset_in && state_r != smpc_pkg::SMPC_ST_RUN;
         resume_r    <= state_r == smpc_pkg::SMPC_ST_HALT && state_nxt == smpc_pkg::SMPC_ST_RUN;
      end
   end

   smpc_brownout_sleep_off_seq u_brownout_sleep_off_seq (
      .ref_clk_in           (ref_clk_in),
      .reset_in             (reset_in),
      .ctrl_wr_in           (mcu_ctrl_wr_in),
      .sleep_off_in         (brownout_sleep_off_in),
      .unlock_in            (brownout_sleep_off_unlock_in),
      .unlock_open_out      (),
      .sleep_off_active_out (sleep_off_active_w)
   );

   // Gating only meaningful while the I/O clock runs
   assign periph_clk_en_out        = clk_r.io ? ~peripheral_clock_gate_in : '0;
   assign periph_access_ok_out     = ~peripheral_clock_gate_in;
   assign clk_en_out               = clk_r;
   assign core_halt_out            = (state_r != smpc_pkg::SMPC_ST_RUN);
   assign sleeping_out             = (state_r == smpc_pkg::SMPC_ST_SLEEP);
   assign resume_irq_out           = resume_r;
   assign reset_vector_out         = reset_vec_r;
   assign adc_start_out            = adc_start_r;
   assign brownout_detector_en_out = !(bod_off_r && state_r == smpc_pkg::SMPC_ST_SLEEP);
   assign brownout_sleep_off_out   = sleep_off_active_w;
   assign active_mode_out          = mode_r;

   sequence s_halt4;
      (state_r == smpc_pkg::SMPC_ST_HALT)[*4] ##1 (state_r == smpc_pkg::SMPC_ST_RUN);
   endsequence

   property p_halt_four;
      @(posedge ref_clk_in) disable iff (reset_in || any_reset_in)
      (state_r == smpc_pkg::SMPC_ST_START && state_nxt == smpc_pkg::SMPC_ST_HALT) |=> s_halt4;
   endproperty
   a_halt_four: assert property (p_halt_four) else $error("halt not four cycles");

   property p_enter_needs_arm;
      @(posedge ref_clk_in) disable iff (reset_in)
      $rose(sleeping_out) |-> $past(sleep_arm_bit_in) && $past(sleep_instr_in);
   endproperty
   a_enter_needs_arm: assert property (p_enter_needs_arm) else $error("sleep without arm");

   property p_reserved_stays;
      @(posedge ref_clk_in) disable iff (reset_in)
      (state_r == smpc_pkg::SMPC_ST_RUN && sleep_mode_select_in[2:1] == 2'b10) |=> !sleeping_out;
   endproperty
   a_reserved_stays: assert property (p_reserved_stays) else $error("reserved mode slept");

   property p_reset_wakes;
      @(posedge ref_clk_in) disable iff (reset_in)
      (any_reset_in && sleeping_out) |=> reset_vector_out && !core_halt_out;
   endproperty
   a_reset_wakes: assert property (p_reset_wakes) else $error("reset did not wake");

   property p_idle_clocks;
      @(posedge ref_clk_in) disable iff (reset_in)
      (sleeping_out && mode_r == smpc_pkg::SMPC_MODE_IDLE) |=> (!clk_en_out.cpu && clk_en_out.io && clk_en_out.adc)
         || !sleeping_out;
   endproperty
   a_idle_clocks: assert property (p_idle_clocks) else $error("idle clocks wrong");

   property p_standby_six;
      @(posedge ref_clk_in) disable iff (reset_in || any_reset_in)
      (sleeping_out && standby_w && !bod_off_r && wake_w) |=> ##6 (state_r == smpc_pkg::SMPC_ST_HALT);
   endproperty
   a_standby_six: assert property (p_standby_six) else $error("standby wake not six");

   property p_bod_back_on;
      @(posedge ref_clk_in) disable iff (reset_in)
      !sleeping_out |-> brownout_detector_en_out;
   endproperty
   a_bod_back_on: assert property (p_bod_back_on) else $error("detector off while awake");

   property p_adc_start;
      @(posedge ref_clk_in) disable iff (reset_in)
      (enter_w && adc_enabled_in && sleep_mode_select_in == 3'h1) |=> adc_start_out;
   endproperty
   a_adc_start: assert property (p_adc_start) else $error("no conversion start");

endmodule
`default_nettype wire

// >>> test/smpc_core_model.sv
// Processor core model: issues the sleep instruction with arm bit and mode code
`timescale 1ns/10ps
`default_nettype none
module smpc_core_model (
   // Clock and reset
   input  wire logic       ref_clk_in,
   input  wire logic       reset_in,
   // Requests from the bench
   input  wire logic       go_in,
   input  wire logic       arm_in,
   input  wire logic [2:0] mode_in,
   // Controller side
   input  wire logic       core_halt_in,
   output logic            sleep_arm_bit_out,
   output logic            sleep_instr_out,
   output logic [2:0]      sleep_mode_select_out
);
   // A halted core executes nothing, so no sleep instruction while halted
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         sleep_arm_bit_out     <= 1'b0;
         sleep_instr_out       <= 1'b0;
         sleep_mode_select_out <= 3'h0;
      end else begin
         sleep_arm_bit_out     <= arm_in;
         sleep_mode_select_out <= mode_in;
         sleep_instr_out       <= go_in & ~core_halt_in;
      end
   end
endmodule
`default_nettype wire

// >>> test/smpc_top_tb.sv
// Self-checking bench for the sleep mode power controller
`timescale 1ns/10ps
`default_nettype none
module smpc_top_tb;
   localparam int WAKE_CYC = 20;
   logic ref_clk_in = 1'b0, reset_in = 1'b1, go = 1'b0, arm_w = 1'b0, arm, instr, xtal = 1'b0;
   logic wr = 1'b0, soff = 1'b0, unl = 1'b0, any_rst = 1'b0, gie = 1'b0;
   logic [2:0] mode_w = 3'h0, mode, am;
   logic [15:0] startup = 16'h000A;
   // Gated peripherals are taken as already disabled by software
   logic [7:0] gate = 8'h5A, pclk, pacc;
   smpc_pkg::smpc_wake_s wake = '0;
   smpc_pkg::smpc_clk_s  clk_en;
   logic halt, resume, rvec, adc_st, det_en, bo_off, sleeping;
   int num_errors = 0;
   int checks = 0;
   int cycles = 0;

   smpc_core_model u_smpc_core_model (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .go_in(go),
      .arm_in(arm_w), .mode_in(mode_w), .core_halt_in(halt), .sleep_arm_bit_out(arm),
      .sleep_instr_out(instr), .sleep_mode_select_out(mode));
   smpc_top #(.BOD_WAKE_CYC(WAKE_CYC)) u_smpc_top (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
      .sleep_arm_bit_in(arm), .sleep_mode_select_in(mode), .sleep_instr_in(instr),
      .ext_crystal_in(xtal), .startup_cycles_in(startup), .mcu_ctrl_wr_in(wr),
      .brownout_sleep_off_in(soff), .brownout_sleep_off_unlock_in(unl),
      .peripheral_clock_gate_in(gate), .wake_in(wake), .any_reset_in(any_rst),
      .global_irq_en_in(gie), .tmr2_enabled_in(1'b1), .tmr2_async_in(1'b0), .adc_enabled_in(1'b1),
      .clk_en_out(clk_en), .periph_clk_en_out(pclk), .periph_access_ok_out(pacc),
      .core_halt_out(halt), .resume_irq_out(resume), .reset_vector_out(rvec),
      .adc_start_out(adc_st), .brownout_detector_en_out(det_en),
      .brownout_sleep_off_out(bo_off), .sleeping_out(sleeping), .active_mode_out(am));

   always #2 ref_clk_in = ~ref_clk_in;

   // Ceiling well above the few hundred cycles the scenarios need
   always @(posedge ref_clk_in) begin
      cycles++;
      if (cycles == 4000) begin
         num_errors++;
         summarize();
      end
   end

   task automatic summarize();
      $display("checks=%0d num_errors=%0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic chk_vec(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_cnt(input int got, input int exp);
      checks++;
      if (got != exp) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Ends one ns after the edge that takes the sleep instruction
   task automatic enter(input logic [2:0] m, input logic a);
      @(posedge ref_clk_in);
      go <= 1'b1;
      arm_w <= a;
      mode_w <= m;
      @(posedge ref_clk_in);
      go <= 1'b0;
      @(posedge ref_clk_in);
      #1;
   endtask

   // Edges from raising a wake source until the handler may run
   task automatic wait_resume(input int exp);
      int k;
      k = 0;
      do begin
         @(posedge ref_clk_in);
         #1;
         k++;
      end while (resume !== 1'b1 && k < 60);
      chk_cnt(k, exp);
      @(posedge ref_clk_in);
      wake <= '0;
   endtask

   task automatic t_reset();
      chk_vec({1'b0, clk_en}, 8'h7F);
      chk_vec({6'h0, halt, sleeping}, 8'h00);
      chk_vec({6'h0, det_en, bo_off}, 8'h02);
      chk_vec(pclk, 8'hA5);
      chk_vec(pacc, 8'hA5);
   endtask

   task automatic t_refuse();
      enter(3'h0, 1'b0);
      chk_vec({7'h0, sleeping}, 8'h00);
      enter(3'h4, 1'b1);
      chk_vec({7'h0, sleeping}, 8'h00);
      enter(3'h5, 1'b1);
      chk_vec({7'h0, sleeping}, 8'h00);
      enter(3'h6, 1'b1);
      chk_vec({7'h0, sleeping}, 8'h00);
   endtask

   task automatic t_idle_quiet();
      enter(3'h0, 1'b1);
      chk_vec({4'h0, sleeping, adc_st, 2'h0}, 8'h0C);
      @(posedge ref_clk_in);
      #1;
      chk_vec({4'h0, clk_en.cpu, clk_en.flash, clk_en.io, clk_en.adc}, 8'h03);
      chk_vec(pclk, 8'hA5);
      @(posedge ref_clk_in);
      wake.periph_irq <= 1'b1;
      wait_resume(6);
      enter(3'h1, 1'b1);
      chk_vec({5'h0, am}, 8'h01);
      chk_vec({7'h0, adc_st}, 8'h01);
      @(posedge ref_clk_in);
      wake.periph_irq <= 1'b1;
      #1;
      chk_vec({4'h0, clk_en.cpu, clk_en.flash, clk_en.io, clk_en.adc}, 8'h01);
      repeat (10) @(posedge ref_clk_in);
      #1;
      chk_vec({7'h0, sleeping}, 8'h01);
      @(posedge ref_clk_in);
      wake.adc_done <= 1'b1;
      wait_resume(6);
   endtask

   task automatic t_deep();
      enter(3'h2, 1'b1);
      chk_vec({7'h0, adc_st}, 8'h00);
      @(posedge ref_clk_in);
      wake.ext_high <= 1'b1;
      #1;
      chk_vec({3'h0, clk_en.cpu, clk_en.flash, clk_en.io, clk_en.adc, clk_en.main_osc}, 8'h00);
      chk_vec(pclk, 8'h00);
      repeat (10) @(posedge ref_clk_in);
      #1;
      chk_vec({7'h0, sleeping}, 8'h01);
      @(posedge ref_clk_in);
      wake.ext_low <= 1'b1;
      wait_resume(15);
      enter(3'h3, 1'b1);
      @(posedge ref_clk_in);
      wake.tmr2_irq <= 1'b1;
      #1;
      chk_vec({5'h0, clk_en.cpu, clk_en.tmr2_sync, clk_en.tmr2_async}, 8'h02);
      repeat (10) @(posedge ref_clk_in);
      #1;
      chk_vec({7'h0, sleeping}, 8'h01);
      @(posedge ref_clk_in);
      gie <= 1'b1;
      wait_resume(15);
      gie <= 1'b0;
   endtask

   task automatic t_standby();
      @(posedge ref_clk_in);
      xtal <= 1'b1;
      enter(3'h6, 1'b1);
      @(posedge ref_clk_in);
      wake.pin_change <= 1'b1;
      #1;
      chk_vec({6'h0, clk_en.cpu, clk_en.main_osc}, 8'h01);
      wait_resume(11);
      enter(3'h7, 1'b1);
      @(posedge ref_clk_in);
      wake.ext_low <= 1'b1;
      wait_resume(11);
      enter(3'h2, 1'b1);
      @(posedge ref_clk_in);
      any_rst <= 1'b1;
      @(posedge ref_clk_in);
      #1;
      chk_vec({6'h0, rvec, halt}, 8'h02);
      any_rst <= 1'b0;
   endtask

   task automatic t_sleep_off();
      int k;
      @(posedge ref_clk_in);
      wr <= 1'b1;
      soff <= 1'b1;
      repeat (8) @(posedge ref_clk_in);
      #1;
      chk_vec({7'h0, bo_off}, 8'h00);
      unl <= 1'b1;
      @(posedge ref_clk_in);
      unl <= 1'b0;
      @(posedge ref_clk_in);
      wr <= 1'b0;
      k = 0;
      while (bo_off !== 1'b1 && k < 10) begin
         @(posedge ref_clk_in);
         #1;
         k++;
      end
      chk_vec({7'h0, bo_off}, 8'h01);
      enter(3'h2, 1'b1);
      chk_vec({6'h0, sleeping, det_en}, 8'h02);
      @(posedge ref_clk_in);
      wake.ext_low <= 1'b1;
      soff <= 1'b0;
      wait_resume(WAKE_CYC + 5);
      chk_vec({7'h0, det_en}, 8'h01);
   endtask

   initial begin
      repeat (4) @(posedge ref_clk_in);
      reset_in <= 1'b0;
      #1;
      t_reset();
      t_refuse();
      t_idle_quiet();
      t_deep();
      t_standby();
      t_sleep_off();
      summarize();
   end
endmodule
`default_nettype wire
